/* File: src/lpc_pkg.sv */
// Constants, register map and carrier types for the low-power and priority control block.
// Assumes a single 40 MHz system clock and a plain single-cycle register port.
// Overview of operation
// - Priority code promotes one maskable source, codes ascending from level interrupt to serial system.
// - Any unassigned priority code promotes the external level interrupt.
// - Priority field writes are taken only while the global interrupt mask is set.
// - Wait instruction stacks registers, then suspends the CPU until a qualifying interrupt.
// - The oscillator keeps running throughout the wait state.
// - In wait the bus keeps reading the address where the condition codes were stacked.
// - Any unmasked interrupt ends the wait state.
// - Timer stops in wait only if interrupts masked and watchdog disabled.
// - Stop halts all clocks including the oscillator; contents are retained.
// - With the stop-disable bit set, the stop instruction is a no-operation.
// - Low on level pin, non-maskable pin or reset leaves stop; clocks restart.
// - A pending falling edge on an edge-sensitive level pin also ends stop.
// - Level pin wakes from stop only while the global interrupt mask is clear.
// - Non-maskable pin always wakes; services only if its mask is clear, else resumes.
// - Reset ending stop performs a full reset sequence, not a resume.
// - An enabled clock monitor produces a reset when stop halts the clocks.
// - Stop exit inserts a stabilization delay when the startup-delay bit is one.
// - Reset sets the startup-delay bit; writable once within 64 E-cycles in normal modes.
// - Power-on reset always gets the delay; a running-clock reset never does.
// - Slow-mode bit inserts a divide-by-16 stage before the internal clock.
// - Slow-mode bit cleared on stop entry and any reset; readable and writable always.
package lpc_pkg;

    // ****************************************************************
    // Register map (indices chosen for this block).
    // ****************************************************************
    localparam logic [3:0] LPC_ADDR_PRIO   = 4'h0;
    localparam logic [3:0] LPC_ADDR_OPTION = 4'h1;
    localparam logic [3:0] LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE   = 4'h2;
    localparam logic [3:0] LPC_ADDR_STATUS = 4'h3;

    // Option register fields.
    localparam int LPC_OPT_IRQ_EDGE   = 5;
    localparam int LPC_OPT_DELAY      = 4;
    localparam int LPC_OPT_CLKMON     = 3;
    localparam int LPC_OPT_FCLKMON    = 0;
    localparam int LPC_SYSTEM_CONFIG_OPTIONS_THREE_SLOW      = 0;

    localparam logic [7:0] LPC_OPTION_RST = 8'h10;
    localparam logic [4:0] LPC_PRIO_RST   = 5'h06;

    // Priority codes.
    localparam logic [4:0] LPC_PRIO_FIRST = 5'h06;
    localparam logic [4:0] LPC_PRIO_LAST  = 5'h14;
    localparam int         LPC_NUM_SRC    = 15;

    // Timing.
    localparam int LPC_ONCE_ECYC   = 64;
    localparam int LPC_SLOW_DIV    = 16;
    localparam int LPC_ECLK_DIV    = 4;
    localparam int LPC_ONCE_CYC    = LPC_ONCE_ECYC * LPC_ECLK_DIV;
    localparam int LPC_STAB_CYC    = 4064;
    localparam int LPC_CCR_OFFSET  = 8;

    typedef enum {
        LPC_RUN,
        LPC_WAIT_STACK,
        LPC_WAIT,
        LPC_STOP,
        LPC_STAB
    } lpc_state_t;

    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lpc_req_t;

    // Wake sources seen from the pins: two active low levels and an active high edge-pending flag.
    typedef struct packed {
        logic irq_n;
        logic nonmaskable_interrupt_pin_n;
        logic irq_edge_pend;
    } lpc_wake_t;

endpackage : lpc_pkg

/* File: src/lpc_prio_decode.sv */
// Priority-select decoder: maps the five-bit code to a one-hot promoted source.
// Assumes the code comes from a register in the main block.
`timescale 1ns/1ps
module lpc_prio_decode
    import lpc_pkg::*;
(
    // Code in
    input  wire logic [4:0]             i_code,
    // One-hot promoted source, bit 0 is the level interrupt
    output logic      [LPC_NUM_SRC-1:0] o_promote
);

    always_comb
    begin
        o_promote = '0;
        if (i_code >= LPC_PRIO_FIRST && i_code <= LPC_PRIO_LAST)
            o_promote[4'(i_code - LPC_PRIO_FIRST)] = 1'b1;
        else
            o_promote[0] = 1'b1;
    end

endmodule // lpc_prio_decode

/* File: src/lpc_ctrl.sv */
// Low-power state control, priority promotion and clock gating for the CPU.
// Assumes the CPU core signals instruction events as one-cycle pulses on i_mclk.
`timescale 1ns/1ps
module lpc_ctrl
    import lpc_pkg::*;
#(
    parameter int STAB_CYC = LPC_STAB_CYC
)
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_por,
    // Register port
    input  wire lpc_req_t    i_req,
    output logic      [7:0]  o_rdata,
    // CPU core
    input  wire logic        i_wait_exec,
    input  wire logic        i_stop_exec,
    input  wire logic        i_stack_done,
    input  wire logic [15:0] i_sp,
    input  wire logic        i_imask,
    input  wire logic        i_xmask,
    input  wire logic        i_stop_disable,
    input  wire logic        i_special_mode,
    input  wire logic        i_int_pending,
    input  wire logic        i_watchdog_disable,
    // External pins
    input  wire lpc_wake_t   i_wake,
    // Clock and state outputs
    output logic             o_osc_en,
    output logic             o_clk_en,
    output logic             o_cpu_suspend,
    output logic             o_timer_run,
    output logic             o_bus_rd,
    output logic      [15:0] o_bus_addr,
    output logic             o_nonmaskable_interrupt_pin_service,
    output logic             o_clkmon_reset,
    output logic      [LPC_NUM_SRC-1:0] o_promote
);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    lpc_state_t  state_reg;
    lpc_state_t  state_next;
    logic [4:0]  prio_reg;
    logic [7:0]  option_reg;
    logic        once_done_reg;
    logic        slow_reg;
    logic [8:0]  once_cnt_reg;
    logic [12:0] stab_cnt_reg;
    logic [3:0]  div_cnt_reg;
    logic [15:0] ccr_addr_reg;
    logic        nonmaskable_interrupt_pin_service_reg;
    logic        clkmon_reset_reg;
    logic        por_delay_reg;
    logic        wake_any;
    logic        once_window;

    lpc_prio_decode u_decode
    (
        .i_code    (prio_reg),
        .o_promote (o_promote)
    );

    // ****************************************************************
    // Register port.
    // ****************************************************************
    // Mask-gated write.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            prio_reg <= LPC_PRIO_RST;
        else if (i_req.wr && i_req.addr == LPC_ADDR_PRIO && i_imask)
            prio_reg <= i_req.wdata[4:0];
    end

    assign once_window = (once_cnt_reg < 9'(LPC_ONCE_CYC)) && !once_done_reg;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            option_reg    <= LPC_OPTION_RST;
            once_done_reg <= 1'b0;
        end
        else if (i_req.wr && i_req.addr == LPC_ADDR_OPTION)
        begin
            if (i_special_mode)
                option_reg <= i_req.wdata;
            else if (once_window)
            begin
                option_reg    <= i_req.wdata;
                once_done_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            once_cnt_reg <= '0;
        else if (once_cnt_reg < 9'(LPC_ONCE_CYC))
            once_cnt_reg <= once_cnt_reg + 9'h001;
    end

    // Slow bit cleared on stop entry.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            slow_reg <= 1'b0;
        else if (state_reg == LPC_RUN && i_stop_exec && !i_stop_disable)
            slow_reg <= 1'b0;
        else if (i_req.wr && i_req.addr == LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE)
            slow_reg <= i_req.wdata[LPC_SYSTEM_CONFIG_OPTIONS_THREE_SLOW];
    end

    // Read data lasts exactly one cycle after the strobe.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_req.rd)
        begin
            case (i_req.addr)
                LPC_ADDR_PRIO:   o_rdata <= {3'h0, prio_reg};
                LPC_ADDR_OPTION: o_rdata <= option_reg;
                LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE:   o_rdata <= {7'h00, slow_reg};
                LPC_ADDR_STATUS: o_rdata <= {5'h00, 3'(state_reg)};
                default:         o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

    // ****************************************************************
    // Wake detection.
    // ****************************************************************
    // Stop wake sources.
    assign wake_any = !i_wake.nonmaskable_interrupt_pin_n
                   || (!i_imask && !i_wake.irq_n && !option_reg[LPC_OPT_IRQ_EDGE])
                   || (!i_imask && i_wake.irq_edge_pend && option_reg[LPC_OPT_IRQ_EDGE]);

    // ****************************************************************
    // State machine.
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            LPC_RUN:
            begin
                if (i_stop_exec && !i_stop_disable)
                    state_next = LPC_STOP;
                else if (i_wait_exec)
                    state_next = LPC_WAIT_STACK;
            end
            LPC_WAIT_STACK:
                if (i_stack_done)
                    state_next = LPC_WAIT;
            LPC_WAIT:
                if (i_int_pending)
                    state_next = LPC_RUN;
            LPC_STOP:
                if (wake_any)
                    // Delay only with the bit set.
                    state_next = option_reg[LPC_OPT_DELAY] ? LPC_STAB : LPC_RUN;
            LPC_STAB:
                if (stab_cnt_reg == '0)
                    state_next = LPC_RUN;
            default:
                state_next = LPC_RUN;
        endcase
    end

    // A reset always restarts at the top; power-on starts stabilizing.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            state_reg <= LPC_RUN;
        else if (por_delay_reg && i_por)
            state_reg <= LPC_STAB;
        else
            state_reg <= state_next;
    end

    // Power-on seen through reset is caught after the release.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            por_delay_reg <= 1'b1;
        else
            por_delay_reg <= 1'b0;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            stab_cnt_reg <= '0;
        else if ((por_delay_reg && i_por) || (state_reg == LPC_STOP && state_next == LPC_STAB))
            stab_cnt_reg <= 13'(STAB_CYC - 1);
        else if (state_reg == LPC_STAB && stab_cnt_reg != '0)
            stab_cnt_reg <= stab_cnt_reg - 13'h0001;
    end

    // Non-maskable wake, serviced only with its mask clear.
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            nonmaskable_interrupt_pin_service_reg <= 1'b0;
        else
            nonmaskable_interrupt_pin_service_reg <= state_reg == LPC_STOP && !i_wake.nonmaskable_interrupt_pin_n && !i_xmask;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            clkmon_reset_reg <= 1'b0;
        else
            clkmon_reset_reg <= state_reg == LPC_STOP
                             && (option_reg[LPC_OPT_CLKMON] || option_reg[LPC_OPT_FCLKMON]);
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            ccr_addr_reg <= 16'h0000;
        else if (state_reg == LPC_RUN && i_wait_exec)
            ccr_addr_reg <= i_sp - 16'(LPC_CCR_OFFSET);
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            div_cnt_reg <= 4'h0;
        else
            div_cnt_reg <= div_cnt_reg + 4'h1;
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Oscillator off only in stop.
    assign o_osc_en       = state_reg != LPC_STOP;
    // The stabilization wait also holds the internal clock, since the oscillator is not yet trusted.
    assign o_clk_en       = (state_reg != LPC_STOP) && (state_reg != LPC_STAB)
                         && (!slow_reg || div_cnt_reg == 4'(LPC_SLOW_DIV - 1));
    assign o_cpu_suspend  = state_reg == LPC_WAIT;
    assign o_timer_run    = !(state_reg == LPC_WAIT && i_imask && i_watchdog_disable)
                         && state_reg != LPC_STOP;
    assign o_bus_rd       = state_reg == LPC_WAIT;
    assign o_bus_addr     = ccr_addr_reg;
    assign o_nonmaskable_interrupt_pin_service = nonmaskable_interrupt_pin_service_reg;
    assign o_clkmon_reset = clkmon_reset_reg;

endmodule // lpc_ctrl

/* File: dv/lpc_cpu_model.sv */
// CPU core stand-in: issues wait and stop instruction pulses and the stacking done pulse.
// Assumes one-cycle command pulses from the bench on i_mclk.
`timescale 1ns/1ps
module lpc_cpu_model
#(
    parameter int STACK_CYC = 9
)
(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // Bench commands
    input  wire logic i_go_wait,
    input  wire logic i_go_stop,
    // Core events
    output logic      o_wait_exec,
    output logic      o_stop_exec,
    output logic      o_stack_done
);
    int cnt;
    // Stack then suspend: one cycle per stacked byte before done.
    always @(posedge i_mclk or posedge i_rst)
        if (i_rst)
        begin
            o_wait_exec  <= 1'b0;
            o_stop_exec  <= 1'b0;
            o_stack_done <= 1'b0;
            cnt          <= 0;
        end
        else
        begin
            o_wait_exec  <= i_go_wait;
            o_stop_exec  <= i_go_stop;
            o_stack_done <= (cnt == 1);
            cnt          <= i_go_wait ? STACK_CYC : (cnt > 0 ? cnt - 1 : 0);
        end
endmodule // lpc_cpu_model

/* File: dv/lpc_ctrl_checker.sv */
// Port-level assertions for the low-power and priority control block.
// Assumes it is bound to lpc_ctrl with the same STAB_CYC.
`timescale 1ns/1ps
module lpc_ctrl_checker
    import lpc_pkg::*;
#(
    parameter int STAB_CYC = LPC_STAB_CYC
)
(
    input wire logic                   i_mclk,
    input wire logic                   i_rst,
    input wire lpc_req_t               i_req,
    input wire logic                   i_wait_exec,
    input wire logic                   i_stop_exec,
    input wire logic [15:0]            i_sp,
    input wire logic                   i_imask,
    input wire logic                   i_stop_disable,
    input wire logic                   i_int_pending,
    input wire logic                   i_watchdog_disable,
    input wire lpc_wake_t              i_wake,
    input wire logic                   o_osc_en,
    input wire logic                   o_clk_en,
    input wire logic                   o_cpu_suspend,
    input wire logic                   o_timer_run,
    input wire logic                   o_bus_rd,
    input wire logic [15:0]            o_bus_addr,
    input wire logic [LPC_NUM_SRC-1:0] o_promote
);
    logic [15:0] sp_reg;
    int          stab_cnt;
    // Slow mode keeps the enable low for 15 cycles, so only longer gaps count as a delay.
    always_ff @(posedge i_mclk or posedge i_rst)
        if (i_rst)
        begin
            sp_reg   <= 16'h0000;
            stab_cnt <= 0;
        end
        else
        begin
            sp_reg   <= i_wait_exec ? i_sp : sp_reg;
            stab_cnt <= (o_osc_en && !o_clk_en) ? stab_cnt + 1 : 0;
        end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_promote_onehot:
        assert property ($onehot(o_promote)) else $error("promote not one-hot");
    a_prio_locked:
        assert property (!i_imask && i_req.wr && i_req.addr == LPC_ADDR_PRIO |=> $stable(o_promote))
        else $error("priority changed while unmasked");
    a_stop_enter:
        assert property (i_stop_exec && !i_stop_disable && o_clk_en && !o_cpu_suspend && !o_bus_rd
                         && i_wake.irq_n && i_wake.nonmaskable_interrupt_pin_n && !i_wake.irq_edge_pend |=> !o_osc_en && !o_clk_en)
        else $error("stop did not halt clocks");
    a_stop_nop:
        assert property (i_stop_exec && i_stop_disable && o_clk_en |=> o_osc_en) else $error("disabled stop halted");
    a_wait_read:
        assert property (o_bus_rd |-> o_osc_en && o_cpu_suspend && o_bus_addr == sp_reg - 16'h0008)
        else $error("wait bus read wrong");
    a_wait_exit:
        assert property (o_bus_rd && i_int_pending |=> !o_bus_rd && !o_cpu_suspend) else $error("wait not left");
    a_timer_gate:
        assert property (o_bus_rd |-> o_timer_run == !(i_imask && i_watchdog_disable)) else $error("timer gate wrong");
    a_irq_masked:
        assert property (!o_osc_en && i_imask && i_wake.nonmaskable_interrupt_pin_n && !i_wake.irq_edge_pend |=> !o_osc_en)
        else $error("masked level pin woke stop");
    a_nonmaskable_interrupt_pin_wake:
        assert property (!o_osc_en && !i_wake.nonmaskable_interrupt_pin_n |-> ##[1:3] o_osc_en) else $error("no wake on nonmaskable");
    a_stab_len:
        assert property ($rose(o_clk_en) && stab_cnt > 16 |-> stab_cnt == STAB_CYC) else $error("delay length wrong");
endmodule // lpc_ctrl_checker

bind lpc_ctrl lpc_ctrl_checker #(.STAB_CYC(STAB_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec),
    .i_sp(i_sp), .i_imask(i_imask), .i_stop_disable(i_stop_disable), .i_int_pending(i_int_pending),
    .i_watchdog_disable(i_watchdog_disable), .i_wake(i_wake), .o_osc_en(o_osc_en), .o_clk_en(o_clk_en),
    .o_cpu_suspend(o_cpu_suspend), .o_timer_run(o_timer_run), .o_bus_rd(o_bus_rd), .o_bus_addr(o_bus_addr),
    .o_promote(o_promote));

/* File: dv/tb.sv */
// Self-checking bench for lpc_ctrl with the CPU stand-in and the bound checker.
// Assumes a 40 MHz clock and a shortened stabilization count.
`timescale 1ns/1ps
module tb;
    import lpc_pkg::*;
    localparam int STAB = 40;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic        i_por  = 1'b1;
    lpc_req_t    req    = '0;
    lpc_wake_t   wake   = 3'b110;
    logic        go_wait = 1'b0, go_stop = 1'b0, wait_exec, stop_exec, stack_done;
    logic        imask = 1'b0, sdis = 1'b0, intp = 1'b0, wdis = 1'b0;
    logic [15:0] sp = 16'h0000, bus_addr;
    logic [7:0]  rdata;
    logic        osc_en, clk_en, susp, trun, bus_rd, xsvc, clkmon;
    logic        xmask = 1'b0, smode = 1'b0;
    logic [14:0] promote;
    int          errors = 0;
    int          checked = 0;

    always #12.5 i_mclk = ~i_mclk;

    lpc_ctrl #(.STAB_CYC(STAB)) u_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_req(req), .o_rdata(rdata),
        .i_wait_exec(wait_exec), .i_stop_exec(stop_exec), .i_stack_done(stack_done), .i_sp(sp),
        .i_imask(imask), .i_xmask(xmask), .i_stop_disable(sdis), .i_special_mode(smode),
        .i_int_pending(intp), .i_watchdog_disable(wdis), .i_wake(wake), .o_osc_en(osc_en),
        .o_clk_en(clk_en), .o_cpu_suspend(susp), .o_timer_run(trun), .o_bus_rd(bus_rd),
        .o_bus_addr(bus_addr), .o_nonmaskable_interrupt_pin_service(xsvc), .o_clkmon_reset(clkmon), .o_promote(promote));
    lpc_cpu_model u_cpu (.i_mclk(i_mclk), .i_rst(i_rst), .i_go_wait(go_wait), .i_go_stop(go_stop),
        .o_wait_exec(wait_exec), .o_stop_exec(stop_exec), .o_stack_done(stack_done));

    function automatic logic [14:0] exp_p(input logic [4:0] c);
        if (c >= LPC_PRIO_FIRST && c <= LPC_PRIO_LAST)
            return 15'h0001 << (c - LPC_PRIO_FIRST);
        return 15'h0001;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_mclk);
        req <= '0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
        @(posedge i_mclk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_mclk);
        req <= '0;
        #1 chk(nm, {8'h00, e}, {8'h00, rdata & m});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic pulse_stop();
        @(posedge i_mclk);
        go_stop <= 1'b1;
        @(posedge i_mclk);
        go_stop <= 1'b0;
    endtask
    task automatic do_rst(input logic p);
        i_por <= p;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
    endtask
    task automatic wait_clk(output int n);
        n = 0;
        while (clk_en !== 1'b1 && n < 500)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #(25 * 8000);
        errors++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        int         n;
        logic [4:0] c;
        n = $urandom(32'hdb38);
        do_rst(1'b1);
        cyc(1);
        wait_clk(n);
        chk("por_delay", 16'(STAB), 16'(n));
        rdc(LPC_ADDR_OPTION, 8'hFF, 8'h10, "option_rst");
        wr(LPC_ADDR_OPTION, 8'h00);
        wr(LPC_ADDR_OPTION, 8'h10);
        rdc(LPC_ADDR_OPTION, 8'hFF, 8'h00, "option_once");
        chk("prio_rst", 16'h0001, {1'b0, promote});
        imask <= 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            wr(LPC_ADDR_PRIO, 8'(i));
            #1 chk("promote", {1'b0, exp_p(5'(i))}, {1'b0, promote});
        end
        wr(LPC_ADDR_PRIO, 8'h0A);
        imask <= 1'b0;
        c = 5'($urandom_range(20, 11));
        wr(LPC_ADDR_PRIO, {3'b000, c});
        #1 chk("prio_locked", {1'b0, exp_p(5'h0A)}, {1'b0, promote});
        sdis <= 1'b1;
        pulse_stop();
        cyc(4);
        chk("stop_nop", 16'h0001, {15'h0000, osc_en});
        sdis <= 1'b0;
        imask <= 1'b1;
        wake.irq_n <= 1'b0;
        pulse_stop();
        cyc(6);
        chk("stop_masked_irq", 16'h0000, {15'h0000, osc_en});
        wake.nonmaskable_interrupt_pin_n <= 1'b0;
        wait_clk(n);
        chk("no_delay", 16'h0001, 16'(n));
        chk("nonmaskable_interrupt_pin_service", 16'h0001, {15'h0000, xsvc});
        wake <= 3'b110;
        xmask <= 1'b1;
        pulse_stop();
        cyc(3);
        wake.nonmaskable_interrupt_pin_n <= 1'b0;
        cyc(1);
        chk("nonmaskable_interrupt_pin_masked_wake", 16'h0001, {15'h0000, osc_en & !xsvc});
        wake <= 3'b110;
        xmask <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            imask <= i[0];
            wdis <= i[1];
            sp <= 16'($urandom_range(16'hFF00, 16'h0100));
            @(posedge i_mclk);
            go_wait <= 1'b1;
            @(posedge i_mclk);
            go_wait <= 1'b0;
            cyc(14);
            chk("wait_rd", 16'h0001, {15'h0000, bus_rd & susp & osc_en});
            chk("wait_osc", 16'h0001, {15'h0000, osc_en});
            chk("wait_addr", sp - 16'(LPC_CCR_OFFSET), bus_addr);
            chk("timer_run", {15'h0000, !(i[0] && i[1])}, {15'h0000, trun});
            intp <= 1'b1;
            cyc(2);
            chk("wait_exit", 16'h0000, {15'h0000, susp});
            intp <= 1'b0;
        end
        imask <= 1'b0;
        do_rst(1'b0);
        cyc(1);
        chk("warm_no_delay", 16'h0001, {15'h0000, clk_en});
        rdc(LPC_ADDR_OPTION, 8'hFF, 8'h10, "option_rst2");
        // Monitor kept above 200 kHz: slow mode still gives a 625 kHz E clock.
        wr(LPC_ADDR_OPTION, 8'h18);
        wr(LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE, 8'h01);
        rdc(LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE, 8'h01, 8'h01, "slow_rw");
        n = 0;
        for (int i = 0; i < 32; i++)
        begin
            cyc(1);
            n += clk_en;
        end
        chk("slow_div", 16'(32 / LPC_SLOW_DIV), 16'(n));
        pulse_stop();
        cyc(3);
        chk("clkmon_rst", 16'h0001, {15'h0000, clkmon});
        wake.irq_n <= 1'b0;
        wait_clk(n);
        chk("stab_delay", 16'(STAB + 1), 16'(n));
        wake <= 3'b110;
        rdc(LPC_ADDR_SYSTEM_CONFIG_OPTIONS_THREE, 8'h01, 8'h00, "slow_clr");
        pulse_stop();
        cyc(3);
        do_rst(1'b0);
        cyc(1);
        chk("stop_reset", 16'h0001, {15'h0000, clk_en});
        rdc(LPC_ADDR_OPTION, 8'hFF, 8'h10, "stop_reset_opt");
        smode <= 1'b1;
        wr(LPC_ADDR_OPTION, 8'h30);
        wr(LPC_ADDR_OPTION, 8'h20);
        rdc(LPC_ADDR_OPTION, 8'hFF, 8'h20, "special_rewrite");
        pulse_stop();
        cyc(3);
        chk("edge_stop", 16'h0000, {15'h0000, osc_en});
        wake.irq_edge_pend <= 1'b1;
        cyc(1);
        chk("edge_wake", 16'h0001, {15'h0000, osc_en & clk_en});
        wake <= 3'b110;
        smode <= 1'b0;
        print_verdict();
    end
endmodule // tb
